// *** pkg/uares_defs.svh ***
// How it works
// [RL1] Status holds parity, framing, overrun; rest zero
// [RL2] Flags hold the last error, no count
// [RL3] Reading status returns flags, then clears them
// [RL4] Reset clears the status register
// [RL5] Unit or receive disable clears all flags
// [RL6] Status is read-only, whole byte, writes ignored
// [RL7] Parity mismatch on completed frame sets flag
// [RL8] Low first stop bit sets framing flag
// [RL9] Frame done with buffer unread sets overrun
// [RL10] Software reads status before receive buffer
// [RL11] Overrun frame is not written to buffer
// [RL12] Only the first stop bit is checked
// [RL13] Even parity: odd count of ones errs
// [RL14] Zero and no parity never flag errors
// [RL15] Receiver always uses one stop bit
`ifndef UARES_DEFS_SVH
`define UARES_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UARES_ADR_CTRL 8'h00
`define UARES_ADR_BAUD 8'h04
`define UARES_ADR_ERR 8'h08
`define UARES_ADR_RXBUF 8'h0C
`define UARES_ADR_IRQ_ST 8'h10
`define UARES_ADR_IRQ_MSK 8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define UARES_CTRL_UNIT_EN 0
`define UARES_CTRL_RX_EN 1
`define UARES_CTRL_PS_LO 2
`define UARES_CTRL_PS_HI 3
`define UARES_CTRL_LEN8 4
`define UARES_CTRL_W 5
`define UARES_CTRL_RST 5'h00
`define UARES_ERR_PAR 2
`define UARES_ERR_FRM 1
`define UARES_ERR_OVR 0
`define UARES_ERR_RST 3'h0
`define UARES_IRQ_DONE 0
`define UARES_IRQ_ERR 1
`define UARES_IRQ_RST 2'h0
`define UARES_BAUD_RST 16'h043D
`define UARES_PAR_NONE 2'h0
`define UARES_PAR_ZERO 2'h1
`define UARES_PAR_ODD 2'h2
`define UARES_PAR_EVEN 2'h3

`endif

// *** pkg/uares_pkg.sv ***
package uares_pkg;

    // Receiver frame states, one-hot
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } uares_rx_state_e;

endpackage : uares_pkg

// *** verilog/uares_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for the asynchronous receive pin
module uares_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    // Idle line is high, so reset to mark level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : uares_sync

// *** verilog/uares_rx_frame.sv ***
`timescale 1ns/1ps
`include "uares_defs.svh"
// Frame sampler: start, data, optional parity, one stop bit
module uares_rx_frame
    import uares_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic rxd_i,
    input wire logic [15:0] div_i,
    input wire logic len8_i,
    input wire logic par_on_i,
    output logic done_o,
    output logic [7:0] data_o,
    output logic par_bit_o,
    output logic stop_bit_o
);
    uares_rx_state_e state;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [7:0] shift;

    // Full bit period less one, shared by every reload
    function automatic logic [15:0] bit_reload(input logic [15:0] d);
        bit_reload = d - 16'h0001;
    endfunction : bit_reload

    // Sequencer; disabling drops any frame in flight
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            state <= RX_IDLE;
            cnt <= 16'h0000;
            bitn <= 4'h0;
            shift <= 8'h00;
            done_o <= 1'b0;
            data_o <= 8'h00;
            par_bit_o <= 1'b0;
            stop_bit_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            if (cnt != 16'h0000 && state != RX_IDLE) begin
                cnt <= cnt - 16'h0001;
            end else begin
                case (state)
                    RX_IDLE: begin
                        if (!rxd_i) begin
                            cnt <= {1'b0, div_i[15:1]}; // Centre of start bit
                            state <= RX_START;
                        end
                    end
                    RX_START: begin
                        cnt <= bit_reload(div_i);
                        bitn <= 4'h0;
                        state <= rxd_i ? RX_IDLE : RX_DATA; // Glitch rejects
                    end
                    RX_DATA: begin
                        shift <= {rxd_i, shift[7:1]};
                        cnt <= bit_reload(div_i);
                        bitn <= bitn + 4'h1;
                        if (bitn == (len8_i ? 4'h7 : 4'h6)) begin
                            state <= par_on_i ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        par_bit_o <= rxd_i;
                        cnt <= bit_reload(div_i);
                        state <= RX_STOP;
                    end
                    RX_STOP: begin
                        // One stop bit only, whatever the transmit length
                        stop_bit_o <= rxd_i; // RL12 RL15
                        data_o <= len8_i ? shift : {1'b0, shift[7:1]};
                        done_o <= 1'b1;
                        state <= RX_IDLE;
                    end
                    default: begin
                        state <= RX_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : uares_rx_frame

// *** verilog/uares_top.sv ***
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "uares_defs.svh"
// Serial receiver with error status, reached over classic Wishbone
module uares_top
    import uares_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    output logic irq_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`UARES_CTRL_W-1:0] ctrl;
    logic [15:0] baud_div;
    logic [2:0] rx_error_status;
    logic [7:0] receive_buffer;
    logic rxbuf_full;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic rxd_sync;
    logic frame_done;
    logic [7:0] frame_data;
    logic frame_par_bit;
    logic frame_stop_bit;
    logic unit_operation_enable;
    logic receive_enable;
    logic rx_run;
    logic [1:0] parity_mode;
    logic len8;
    logic par_on;
    logic bus_req;
    logic bus_rd;
    logic bus_wr;
    logic rd_err;
    logic rd_rxbuf;
    logic parity_error;
    logic framing_error;
    logic overrun_error;
    logic any_error;
    logic [2:0] new_err;
    logic [2:0] next_status;
    logic [31:0] next_rdata;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Address match for a bus cycle
    function automatic logic adr_hit(input logic [7:0] a, input logic [7:0] r);
        adr_hit = (a == r);
    endfunction : adr_hit

    // Parity judgement; only odd and even modes ever report a mismatch
    function automatic logic par_mismatch(
        input logic [1:0] mode,
        input logic [7:0] d,
        input logic p
    );
        logic odd_ones;
        odd_ones = ^{d, p};
        case (mode)
            `UARES_PAR_EVEN: par_mismatch = odd_ones; // RL13
            `UARES_PAR_ODD: par_mismatch = !odd_ones;
            default: par_mismatch = 1'b0; // RL14
        endcase
    endfunction : par_mismatch

    // Write-one-to-clear with set winning over the clear
    function automatic logic [1:0] w1c_set(
        input logic [1:0] cur,
        input logic [1:0] clr,
        input logic [1:0] set
    );
        w1c_set = (cur & ~clr) | set;
    endfunction : w1c_set

    // ----------------------------------------
    // Control fields
    // ----------------------------------------

    // Decoded control bits steer the receiver and error judgement
    assign unit_operation_enable = ctrl[`UARES_CTRL_UNIT_EN];
    assign receive_enable = ctrl[`UARES_CTRL_RX_EN];
    assign rx_run = unit_operation_enable && receive_enable;
    assign parity_mode = {ctrl[`UARES_CTRL_PS_HI], ctrl[`UARES_CTRL_PS_LO]};
    assign len8 = ctrl[`UARES_CTRL_LEN8];
    // Zero parity still carries a parity bit on the line; it is just not judged
    assign par_on = (parity_mode != `UARES_PAR_NONE);

    // ----------------------------------------
    // Receive path
    // ----------------------------------------

    // The pin is asynchronous, so it is synchronised before any use
    uares_sync u_rxd_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(rxd_i),
        .q_o(rxd_sync)
    );

    // Frame sampler is held idle while the receiver is disabled
    uares_rx_frame u_rx_frame (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(rx_run),
        .rxd_i(rxd_sync),
        .div_i(baud_div),
        .len8_i(len8),
        .par_on_i(par_on),
        .done_o(frame_done),
        .data_o(frame_data),
        .par_bit_o(frame_par_bit),
        .stop_bit_o(frame_stop_bit)
    );

    // ----------------------------------------
    // Error detection at frame completion
    // ----------------------------------------

    // Errors are judged only in the cycle a frame completes
    assign parity_error = frame_done && par_mismatch(parity_mode, frame_data,
        frame_par_bit); // RL7
    assign framing_error = frame_done && !frame_stop_bit; // RL8
    // Buffer still unread when the next frame lands
    assign overrun_error = frame_done && rxbuf_full; // RL9
    assign any_error = parity_error || framing_error || overrun_error;
    assign new_err = {parity_error, framing_error, overrun_error};

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // One request per classic cycle; ack masks the second beat
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_rd = bus_req && !wb_we_i;
    assign bus_wr = bus_req && wb_we_i;
    // Whole-byte status read, any lane pattern counts as a read
    assign rd_err = bus_rd && adr_hit(wb_adr_i, `UARES_ADR_ERR); // RL6
    assign rd_rxbuf = bus_rd && adr_hit(wb_adr_i, `UARES_ADR_RXBUF);

    // Ack comes one cycle after the request, for any address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // ----------------------------------------
    // Error status register
    // ----------------------------------------

    // Read-clear happens on the same edge the old value is latched for the
    // reader, so the reader always sees the flags before they vanish.
    // A frame ending in that edge still sets its flag: the set wins.
    // Flags only ever set, with no count, so each one reports the last
    // occurrence of its error since the previous read.
    always_comb begin
        next_status = rx_error_status;
        if (rd_err) begin
            next_status = `UARES_ERR_RST; // RL3
        end
        next_status = next_status | new_err; // RL2
        if (!rx_run) begin
            next_status = `UARES_ERR_RST; // RL5
        end
    end

    // Status has no write path at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_error_status <= `UARES_ERR_RST; // RL4
        end else begin
            rx_error_status <= next_status; // RL6
        end
    end

    // ----------------------------------------
    // Receive buffer
    // ----------------------------------------

    // An overrun frame is dropped; the buffer keeps the unread data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            receive_buffer <= 8'h00;
        end else if (frame_done && !rxbuf_full) begin
            receive_buffer <= frame_data; // RL11
        end
    end

    // Full flag; a frame landing during the read keeps it set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxbuf_full <= 1'b0;
        end else if (frame_done) begin
            rxbuf_full <= 1'b1;
        end else if (rd_rxbuf || !rx_run) begin
            rxbuf_full <= 1'b0;
        end
    end

    // ----------------------------------------
    // Control and baud registers
    // ----------------------------------------

    // Control byte lives in lane 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `UARES_CTRL_RST;
        end else if (bus_wr && wb_sel_i[0] && adr_hit(wb_adr_i, `UARES_ADR_CTRL)) begin
            ctrl <= wb_dat_i[`UARES_CTRL_W-1:0];
        end
    end

    // Clocks per bit; change only with the receiver off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_div <= `UARES_BAUD_RST;
        end else if (bus_wr && adr_hit(wb_adr_i, `UARES_ADR_BAUD)) begin
            if (wb_sel_i[0]) begin
                baud_div[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                baud_div[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------

    // Sticky events: frame stored or error seen; write one to clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= `UARES_IRQ_RST;
        end else begin
            irq_status <= w1c_set(irq_status,
                (bus_wr && wb_sel_i[0] && adr_hit(wb_adr_i, `UARES_ADR_IRQ_ST))
                    ? wb_dat_i[1:0] : 2'h0,
                {any_error, frame_done && !rxbuf_full});
        end
    end

    // Mask shares the status layout; one enables the source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `UARES_IRQ_RST;
        end else if (bus_wr && wb_sel_i[0] && adr_hit(wb_adr_i, `UARES_ADR_IRQ_MSK)) begin
            irq_mask <= wb_dat_i[1:0];
        end
    end

    // Level output, registered so it never glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------

    // Unused bits and unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `UARES_ADR_CTRL: next_rdata[`UARES_CTRL_W-1:0] = ctrl;
            `UARES_ADR_BAUD: next_rdata[15:0] = baud_div;
            `UARES_ADR_ERR: next_rdata[2:0] = rx_error_status; // RL1
            `UARES_ADR_RXBUF: next_rdata[7:0] = receive_buffer;
            `UARES_ADR_IRQ_ST: next_rdata[1:0] = irq_status;
            `UARES_ADR_IRQ_MSK: next_rdata[1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Data is latched with ack and cleared between reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_rd) begin
            wb_dat_o <= next_rdata;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

endmodule : uares_top

// *** verif/uares_tx_model.sv ***
`timescale 1ns/1ps
// Far-side transmitter: idle high, start, data LSB first, parity, one stop
module uares_tx_model (
    input wire logic clk_i,
    output logic rxd_o
);
    initial rxd_o = 1'b1;

    // Each bit held for div clocks; a final idle bit lets the receiver settle
    task automatic send(input int div, input int nb, input logic [1:0] pm,
                        input logic [7:0] d, input logic pbad, input logic sbad);
        logic q[$];
        logic p;
        q.push_back(1'b0);
        for (int i = 0; i < nb; i++) begin
            q.push_back(d[i]);
        end
        p = (pm == 2'h1) ? 1'b0 : ((pm == 2'h3) ? ^d : ~^d);
        if (pm != 2'h0) begin
            q.push_back(p ^ pbad);
        end
        q.push_back(~sbad);
        q.push_back(1'b1);
        foreach (q[i]) begin
            rxd_o <= q[i];
            repeat (div) @(posedge clk_i);
        end
    endtask : send
endmodule : uares_tx_model

// *** verif/uares_top_properties.sv ***
`timescale 1ns/1ps
`include "uares_defs.svh"
// Checks on the top ports; payload is judged by the bench
module uares_top_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rxd_i,
    input wire logic irq_o
);
    logic rd_err;
    logic wr_ctrl;
    logic rx_off;
    // Master holds the request through the ack cycle, so decode there
    assign rd_err = wb_ack_o && !wb_we_i && wb_adr_i == `UARES_ADR_ERR;
    assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `UARES_ADR_CTRL;
    // Tracks a disabled receiver, during which no error may be recorded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_off <= 1'b1;
        end else if (wr_ctrl) begin
            rx_off <= (wb_dat_i[1:0] != 2'h3);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i)
        else $error("ack without request");
    AST_IDLE_DATA: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_ERR_LAYOUT: assert property (rd_err |-> wb_dat_o[31:3] == 29'h0)
        else $error("status upper bits not zero");
    AST_ERR_OFF: assert property (rd_err && rx_off |-> wb_dat_o[2:0] == 3'h0)
        else $error("error flag while receiver disabled");
    AST_RST_CLEAN: assert property ($fell(rst_i)
        |-> !wb_ack_o && wb_dat_o == 32'h0 && !irq_o)
        else $error("outputs not clear after reset");
    AST_IRQ_MASKED: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == `UARES_ADR_IRQ_MSK && wb_dat_i[1:0] == 2'h0 |=> !irq_o)
        else $error("irq high with mask zero");
    AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    cover property (rd_err && wb_dat_o[2:0] != 3'h0);
    cover property (irq_o);
    cover property (rd_err && rx_off);
endmodule : uares_top_properties

bind uares_top uares_top_properties u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i, .irq_o);

// *** verif/uares_top_tb.sv ***
`timescale 1ns/1ps
`include "uares_defs.svh"
module uares_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] dat_o;
    logic ack;
    logic rxd;
    logic irq;
    logic [31:0] rd;
    int mismatches = 0;
    int n_tests = 0;
    // Reference model: error flags, buffer, fill flag, irq status and mask
    int m_err = 0, m_buf = 0, m_full = 0, m_ist = 0, m_msk = 0;

    always #4 clk_i = ~clk_i;

    uares_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rxd_i(rxd), .irq_o(irq));
    uares_tx_model tx (.clk_i(clk_i), .rxd_o(rxd));

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg

    // Irq output lags a register change by one more cycle
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk_i);
        n_tests++;
        if (irq !== e) begin
            mismatches++;
            $display("BAD irq expected %b seen %b", e, irq);
        end
    endtask : chk_irq

    // Classic cycle; waits for ack as long as it takes, the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk_reg(nm, e, rd);
    endtask : rdc

    task automatic err_rd();
        rdc(`UARES_ADR_ERR, m_err, "err_status");
        m_err = 0;
    endtask : err_rd

    task automatic buf_rd();
        rdc(`UARES_ADR_RXBUF, m_buf, "rx_buffer");
        m_full = 0;
    endtask : buf_rd

    // Disabling either enable drops flags and the fill state
    task automatic ctrl(input logic [4:0] v);
        bus(1'b1, `UARES_ADR_CTRL, {27'h0, v});
        if (v[1:0] != 2'h3) begin
            m_err = 0;
            m_full = 0;
        end
    endtask : ctrl

    task automatic frame(input int d, input int nb, input logic [1:0] pm,
                         input logic pb, input logic sb);
        int e;
        tx.send(16, nb, pm, d[7:0], pb, sb);
        repeat (4) @(posedge clk_i);
        e = (sb ? 2 : 0) | ((pm >= 2 && pb) ? 4 : 0);
        if (m_full != 0) e |= 1;
        else begin
            m_buf = d;
            m_full = 1;
            m_ist |= 1;
        end
        m_err |= e;
        if (e != 0) m_ist |= 2;
    endtask : frame

    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int d, nb;
        logic [1:0] pm;
        void'($urandom(33));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`UARES_ADR_ERR, 0, "err_status");
        rdc(`UARES_ADR_CTRL, 0, "ctrl");
        rdc(`UARES_ADR_BAUD, 32'h043D, "baud");
        rdc(8'h18, 0, "unmapped");
        bus(1'b1, `UARES_ADR_ERR, 32'hFF);
        rdc(`UARES_ADR_ERR, 0, "err_status");
        bus(1'b1, `UARES_ADR_BAUD, 16);
        bus(1'b1, `UARES_ADR_IRQ_MSK, 3);
        m_msk = 3;
        // Every parity mode, both lengths, parity and stop faults
        for (int i = 0; i < 8; i++) begin
            pm = 2'(i % 4);
            nb = (i < 4) ? 8 : 7;
            ctrl({nb == 8, pm[1], pm[0], 2'h3});
            d = $urandom & ((nb == 8) ? 'hFF : 'h7F);
            frame(d, nb, pm, (i < 4) ? 1'b1 : 1'($urandom), i == 0 || i == 6);
            chk_irq((m_ist & m_msk) != 0);
            err_rd();
            err_rd();
            buf_rd();
            bus(1'b1, `UARES_ADR_IRQ_ST, 3);
            m_ist = 0;
            chk_irq(1'b0);
        end
        // Back to 8-bit even parity; the loop left 7-bit framing set
        ctrl(5'h1F);
        // Second frame lands on an unread buffer
        frame(8'h5A, 8, 2'h3, 1'b0, 1'b1);
        frame(8'hA5, 8, 2'h3, 1'b0, 1'b0);
        err_rd();
        buf_rd();
        // Either enable going low wipes recorded errors
        for (int k = 1; k < 3; k++) begin
            frame(8'h33, 8, 2'h3, 1'b1, 1'b1);
            ctrl(5'h10 | 5'(k));
            ctrl(5'h1F);
            err_rd();
        end
        bus(1'b1, `UARES_ADR_IRQ_MSK, 0);
        m_msk = 0;
        chk_irq(1'b0);
        bus(1'b1, `UARES_ADR_IRQ_MSK, 3);
        m_msk = 3;
        chk_irq((m_ist & m_msk) != 0);
        bus(1'b1, `UARES_ADR_IRQ_ST, 3);
        m_ist = 0;
        chk_irq(1'b0);
        rdc(`UARES_ADR_IRQ_ST, 0, "irq_status");
        end_of_test();
    end

    // Watchdog well beyond the expected run of a few thousand cycles
    initial begin
        repeat (50000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end
endmodule : uares_top_tb
